// [inc/btc_consts.vh]
// Constants for the bus transceiver control logic: status bit positions,
// reset values and default timing counts.
// Assumes a single 200 MHz system clock and synchronous active-high reset.
`ifndef BTC_CONSTS_VH
`define BTC_CONSTS_VH

// Status word bit positions
`define BTC_ST_TIMEOUT      0
`define BTC_ST_GUARDIAN     1
`define BTC_ST_OVERTEMP     2
`define BTC_ST_BUS_ERR      3
`define BTC_ST_SPI_ERR      4
`define BTC_ST_UV_SUPPLY    5
`define BTC_ST_UV_LOGIC     6
`define BTC_ST_WAKE         7
`define BTC_ST_ACTIVITY_N   8
`define BTC_ST_POWER_ON     9
`define BTC_ST_WIDTH        10

// Reset values
`define BTC_ST_RESET        10'h200
`define BTC_MODE_RESET      1'b0

// Default timing counts in clock cycles
`define BTC_FILTER_CYC      16
`define BTC_MODE_CHG_CYC    64
`define BTC_REACT_CYC       8
`define BTC_TIMEOUT_CYC     1000
`define BTC_CNT_W           16

`endif

// [core/btc_filter.v]
// Glitch filter for a synchronised level: output changes only after the
// input has held a new value for FILT_CYC consecutive cycles.
// Assumes the input is already in the CLK_SYS domain.
`timescale 1ns/100ps
`default_nettype none
`include "btc_consts.vh"

module btc_filter #(
   parameter FILT_CYC = `BTC_FILTER_CYC,
   parameter CNT_W    = `BTC_CNT_W,
   parameter INIT     = 1'b0
) (
   // Clock and reset
   input  wire             clk,
   input  wire             srst,
   // Level
   input  wire             din,
   output reg              dout
);

   reg [CNT_W-1:0] cnt_reg;

   always @(posedge clk) begin
      if (srst) begin
         cnt_reg <= {CNT_W{1'b0}};
         dout    <= INIT;
      end else if (din == dout) begin
         cnt_reg <= {CNT_W{1'b0}};
      end else if (cnt_reg >= FILT_CYC[CNT_W-1:0] - 1'b1) begin
         cnt_reg <= {CNT_W{1'b0}};
         dout    <= din;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

endmodule // btc_filter

`default_nettype wire

// [core/btc_ctrl.v]
// Control logic of a differential bus transceiver: transmit gating,
// receive path, host mode control, fault/wake signalling and status word.
// Assumes pins arrive asynchronously and analog detectors give levels.
`timescale 1ns/100ps
`default_nettype none
`include "btc_consts.vh"

module btc_ctrl #(
   parameter FILT_CYC    = `BTC_FILTER_CYC,
   parameter MODE_CYC    = `BTC_MODE_CHG_CYC,
   parameter REACT_CYC   = `BTC_REACT_CYC,
   parameter TIMEOUT_CYC = `BTC_TIMEOUT_CYC,
   parameter CNT_W       = `BTC_CNT_W
) (
   // Clock and reset
   input  wire                     CLK_SYS,
   input  wire                     SRST,
   // Communication controller side
   input  wire                     TX_DATA,
   input  wire                     TX_GATE_N,
   output reg                      RX_DATA,
   // Bus guardian
   input  wire                     GUARDIAN_ENABLE,
   // Host
   input  wire                     STANDBY_REQ_N,
   output reg                      FAULT_WAKE_N,
   // Bus side: receiver comparators and transmitter drive
   input  wire                     BUS_NEG_DET,
   input  wire                     BUS_POS_DET,
   input  wire                     STAGE_OFF_DET,
   output reg                      TX_ON,
   output reg                      TX_POS,
   output reg                      BIAS_NORMAL,
   // Detectors
   input  wire                     UV_SUPPLY,
   input  wire                     UV_LOGIC,
   input  wire                     OVERTEMP,
   input  wire                     BUS_ERROR,
   input  wire                     SPI_ERROR,
   input  wire                     WAKE_DET,
   // Status access
   input  wire                     STATUS_READ,
   output reg  [`BTC_ST_WIDTH-1:0] STATUS,
   output reg                      SERIAL_OUT_OE,
   output reg                      NORMAL_MODE
);

   // =====================================================================
   // Input synchronisers
   // =====================================================================
   localparam NSYNC = 12;
   wire [NSYNC-1:0] raw_in = {TX_DATA, TX_GATE_N, GUARDIAN_ENABLE, STANDBY_REQ_N,
                              BUS_NEG_DET, BUS_POS_DET, STAGE_OFF_DET,
                              UV_SUPPLY, UV_LOGIC, OVERTEMP, BUS_ERROR, WAKE_DET};
   reg  [NSYNC-1:0] s1_reg;
   reg  [NSYNC-1:0] s2_reg;
   reg              spi_err_s1_reg;
   reg              spi_err_s2_reg;

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         always @(posedge CLK_SYS) begin
            if (SRST) begin
               s1_reg[gi] <= 1'b0;
               s2_reg[gi] <= 1'b0;
            end else begin
               s1_reg[gi] <= raw_in[gi];
               s2_reg[gi] <= s1_reg[gi];
            end
         end
      end
   endgenerate

   always @(posedge CLK_SYS) begin
      if (SRST) begin
         spi_err_s1_reg <= 1'b0;
         spi_err_s2_reg <= 1'b0;
      end else begin
         spi_err_s1_reg <= SPI_ERROR;
         spi_err_s2_reg <= spi_err_s1_reg;
      end
   end

   wire uv_supply = s2_reg[4];
   wire uv_logic  = s2_reg[3];
   wire uv_any    = uv_supply | uv_logic;

   // Logic undervoltage forces pin defaults
   wire tx_data_i  = uv_logic ? 1'b0 : s2_reg[11];
   wire tx_gate_ni = uv_logic ? 1'b1 : s2_reg[10];
   wire guard_i    = uv_logic ? 1'b0 : s2_reg[9];
   wire stby_req_i = uv_logic ? 1'b0 : s2_reg[8];
   wire bus_neg    = s2_reg[7];
   wire bus_pos    = s2_reg[6];
   wire stage_off  = s2_reg[5];
   wire overtemp   = s2_reg[2];
   wire bus_err    = s2_reg[1];
   wire wake_det   = s2_reg[0];
   wire spi_err    = uv_logic ? 1'b0 : spi_err_s2_reg;

   // =====================================================================
   // Host mode control
   // =====================================================================
   wire host_normal;

   btc_filter #(
      .FILT_CYC (FILT_CYC),
      .CNT_W    (CNT_W),
      .INIT     (1'b0)
   ) u_stby_filt (
      .clk      (CLK_SYS),
      .srst     (SRST),
      .din      (stby_req_i),
      .dout     (host_normal)
   );

   reg             mode_reg;
   reg [CNT_W-1:0] mode_cnt_reg;
   wire            mode_target = host_normal & ~uv_any;

   always @(posedge CLK_SYS) begin
      if (SRST) begin
         mode_reg     <= `BTC_MODE_RESET;
         mode_cnt_reg <= {CNT_W{1'b0}};
      end else if (uv_any) begin
         mode_reg     <= 1'b0;
         mode_cnt_reg <= {CNT_W{1'b0}};
      end else if (mode_target == mode_reg) begin
         mode_cnt_reg <= {CNT_W{1'b0}};
      end else if (mode_cnt_reg >= MODE_CYC[CNT_W-1:0] - FILT_CYC[CNT_W-1:0] - 1'b1) begin
         mode_reg     <= mode_target;
         mode_cnt_reg <= {CNT_W{1'b0}};
      end else begin
         mode_cnt_reg <= mode_cnt_reg + 1'b1;
      end
   end

   reg  mode_d_reg;
   wire mode_change = mode_d_reg ^ mode_reg;

   // =====================================================================
   // Transmit gating and time-out
   // =====================================================================
   reg             gate_d_reg;
   reg             armed_reg;
   reg             timeout_reg;
   reg [CNT_W-1:0] to_cnt_reg;
   wire            gate_fall = gate_d_reg & ~tx_gate_ni;
   wire            tx_block  = timeout_reg | overtemp;
   wire            tx_active = mode_reg & armed_reg & guard_i & ~tx_gate_ni & ~tx_block;

   always @(posedge CLK_SYS) begin
      if (SRST) begin
         gate_d_reg  <= 1'b1;
         armed_reg   <= 1'b0;
         timeout_reg <= 1'b0;
         to_cnt_reg  <= {CNT_W{1'b0}};
      end else begin
         gate_d_reg <= tx_gate_ni;
         if (!mode_reg || tx_gate_ni || !guard_i)
            armed_reg <= 1'b0;
         else if (gate_fall)
            armed_reg <= 1'b1;
         // Time-out counts in normal mode while gate and guardian both allow sending
         if (!mode_reg || tx_gate_ni || !guard_i) begin
            to_cnt_reg  <= {CNT_W{1'b0}};
            timeout_reg <= 1'b0;
         end else if (to_cnt_reg >= TIMEOUT_CYC[CNT_W-1:0] - 1'b1) begin
            timeout_reg <= 1'b1;
         end else begin
            to_cnt_reg <= to_cnt_reg + 1'b1;
         end
      end
   end

   always @(posedge CLK_SYS) begin
      if (SRST) begin
         TX_ON       <= 1'b0;
         TX_POS      <= 1'b1;
         BIAS_NORMAL <= 1'b0;
         NORMAL_MODE <= 1'b0;
         mode_d_reg  <= 1'b0;
      end else begin
         TX_ON       <= tx_active & (guard_i | ~mode_reg);
         TX_POS      <= tx_data_i;
         BIAS_NORMAL <= mode_reg;
         NORMAL_MODE <= mode_reg;
         mode_d_reg  <= mode_reg;
      end
   end

   // =====================================================================
   // Event detection, reaction delay and status word
   // =====================================================================
   wire guard_evt = mode_reg & ~guard_i & stage_off;
   wire [`BTC_ST_WIDTH-1:0] cause;
   assign cause[`BTC_ST_TIMEOUT]    = timeout_reg;
   assign cause[`BTC_ST_GUARDIAN]   = guard_evt;
   assign cause[`BTC_ST_OVERTEMP]   = mode_reg & overtemp;
   assign cause[`BTC_ST_BUS_ERR]    = mode_reg & bus_err;
   assign cause[`BTC_ST_SPI_ERR]    = spi_err;
   assign cause[`BTC_ST_UV_SUPPLY]  = uv_supply;
   assign cause[`BTC_ST_UV_LOGIC]   = uv_logic;
   assign cause[`BTC_ST_WAKE]       = ~mode_reg & ~host_normal & wake_det;
   assign cause[`BTC_ST_ACTIVITY_N] = 1'b0;
   assign cause[`BTC_ST_POWER_ON]   = 1'b0;

   wire            any_cause = |cause;
   reg [CNT_W-1:0] react_cnt_reg;
   reg             fault_lat_reg;
   wire            react_done = react_cnt_reg >= REACT_CYC[CNT_W-1:0] - 1'b1;
   wire            clr_req    = STATUS_READ | mode_change;
   reg  [`BTC_ST_WIDTH-1:0] sticky_reg;
   reg  [`BTC_ST_WIDTH-1:0] sticky_next;
   reg                      act_n_reg;

   always @* begin
      sticky_next = sticky_reg;
      if (clr_req)
         sticky_next = sticky_reg & cause;
      sticky_next = sticky_next | (react_done ? cause : {`BTC_ST_WIDTH{1'b0}});
      sticky_next[`BTC_ST_ACTIVITY_N] = 1'b0;
      if (clr_req)
         sticky_next[`BTC_ST_POWER_ON] = 1'b0;
      else
         sticky_next[`BTC_ST_POWER_ON] = sticky_reg[`BTC_ST_POWER_ON];
   end

   always @(posedge CLK_SYS) begin
      if (SRST) begin
         react_cnt_reg <= {CNT_W{1'b0}};
         fault_lat_reg <= 1'b0;
         sticky_reg    <= `BTC_ST_RESET;
         act_n_reg     <= 1'b1;
      end else begin
         if (!any_cause)
            react_cnt_reg <= {CNT_W{1'b0}};
         else if (!react_done)
            react_cnt_reg <= react_cnt_reg + 1'b1;
         if (any_cause && react_done)
            fault_lat_reg <= 1'b1;
         else if (clr_req && !any_cause)
            fault_lat_reg <= 1'b0;
         sticky_reg <= sticky_next;
         act_n_reg  <= mode_reg ? ~(bus_neg | bus_pos) : 1'b1;
      end
   end

   // =====================================================================
   // Output pins
   // =====================================================================
   always @(posedge CLK_SYS) begin
      if (SRST) begin
         FAULT_WAKE_N  <= 1'b1;
         RX_DATA       <= 1'b1;
         STATUS        <= `BTC_ST_RESET;
         SERIAL_OUT_OE <= 1'b0;
      end else begin
         STATUS        <= {sticky_next[`BTC_ST_WIDTH-1:`BTC_ST_ACTIVITY_N+1], act_n_reg,
                           sticky_next[`BTC_ST_ACTIVITY_N-1:0]};
         SERIAL_OUT_OE <= ~uv_logic;
         if (uv_logic) begin
            FAULT_WAKE_N <= 1'b0;
            RX_DATA      <= 1'b0;
         end else if (mode_reg) begin
            FAULT_WAKE_N <= ~fault_lat_reg;
            RX_DATA      <= ~bus_neg;
         end else begin
            FAULT_WAKE_N <= ~fault_lat_reg;
            RX_DATA      <= ~(fault_lat_reg & sticky_reg[`BTC_ST_WAKE]);
         end
      end
   end

endmodule // btc_ctrl

`default_nettype wire

// [testbench/btc_ctrl_monitor.sv]
// Port checker for btc_ctrl.
// Assumes it is bound to btc_ctrl; one clock, synchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "btc_consts.vh"
module btc_ctrl_monitor #(
   parameter FILT_CYC = 4,
   parameter MODE_CYC = 20
) (
   // Clock and reset
   input wire logic CLK_SYS, SRST,
   // Pins
   input wire logic TX_GATE_N, RX_DATA, GUARDIAN_ENABLE, STANDBY_REQ_N, FAULT_WAKE_N,
   input wire logic BUS_NEG_DET, TX_ON, UV_SUPPLY, UV_LOGIC, STATUS_READ, NORMAL_MODE,
   input wire logic [`BTC_ST_WIDTH-1:0] STATUS
);
   // ====
   // Cycles spent with mode differing from the host request
   logic [7:0] mc_reg;
   always @(posedge CLK_SYS) begin
      if (SRST || UV_SUPPLY || UV_LOGIC || STANDBY_REQ_N == NORMAL_MODE)
         mc_reg <= 8'h00;
      else if (mc_reg != 8'hFF)
         mc_reg <= mc_reg + 8'h01;
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   chk_guard_cut: assert property ((!GUARDIAN_ENABLE)[*6] |-> !TX_ON)
      else $error("tx on with guardian low");
   chk_standby_no_tx: assert property (!NORMAL_MODE && !$past(NORMAL_MODE) |-> !TX_ON)
      else $error("tx on in standby");
   chk_rx_neg: assert property ((NORMAL_MODE && BUS_NEG_DET)[*6] |-> !RX_DATA)
      else $error("rx not low on negative bus");
   chk_rx_pos_idle: assert property ((NORMAL_MODE && !BUS_NEG_DET)[*6] |-> RX_DATA)
      else $error("rx not high");
   chk_tx_start: assert property ($rose(TX_ON) |->
      NORMAL_MODE && !$past(TX_GATE_N, 3) && $past(GUARDIAN_ENABLE, 3))
      else $error("tx started without cause");
   chk_timeout_fault: assert property ($rose(STATUS[`BTC_ST_TIMEOUT]) |->
      ##[0:8] (!FAULT_WAKE_N && !TX_ON))
      else $error("timeout not signalled");
   chk_guard_flag: assert property ($rose(STATUS[`BTC_ST_GUARDIAN]) |-> ##[0:8] !FAULT_WAKE_N)
      else $error("guardian flag without fault");
   chk_fault_latch: assert property ((!FAULT_WAKE_N && !STATUS_READ && $stable(NORMAL_MODE))[*3]
      |=> !FAULT_WAKE_N)
      else $error("fault released without clear");
   chk_mode_filter: assert property ($rose(NORMAL_MODE) |->
      $past(STANDBY_REQ_N, 8) && $past(STANDBY_REQ_N, 12))
      else $error("mode changed on short pulse");
   chk_mode_bound: assert property (mc_reg <= FILT_CYC + MODE_CYC + 10)
      else $error("mode change too slow");
   chk_uv_logic_out: assert property (UV_LOGIC[*4] |-> !FAULT_WAKE_N && !RX_DATA)
      else $error("outputs not low under logic undervoltage");
   cover property ($rose(TX_ON));
   cover property ($rose(STATUS[`BTC_ST_TIMEOUT]));
   cover property ($fell(NORMAL_MODE));
endmodule // btc_ctrl_monitor
`default_nettype wire

// [testbench/btc_bus_model.sv]
// Behavioural bus: own transmitter plus a remote node.
// Assumes remote_sel 0 idle, 1 negative, 2 positive.
`timescale 1ns/100ps
`default_nettype none
module btc_bus_model (
   // Own transmitter
   input  wire logic       tx_on,
   input  wire logic       tx_pos,
   // Remote node and detectors
   input  wire logic [1:0] remote_sel,
   output logic            neg_det,
   output logic            pos_det,
   output logic            stage_off
);
   // ====
   assign neg_det   = (tx_on && !tx_pos) || remote_sel == 2'h1;
   assign pos_det   = (tx_on && tx_pos) || remote_sel == 2'h2;
   assign stage_off = !tx_on;
endmodule // btc_bus_model
`default_nettype wire

// [testbench/test_bus_transceiver_ctrl_logic.sv]
// Self-checking bench for btc_ctrl with shortened counts.
// Assumes btc_bus_model and btc_ctrl_monitor are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "btc_consts.vh"
module test_bus_transceiver_ctrl_logic;
   logic clk = 1'b0, srst = 1'b1, txd = 1'b0, gate_n = 1'b1, guard = 1'b1, stby_n = 1'b1;
   logic neg, pos, soff, ron, rpos, rx, fault, bias, oe, nmode, rd = 1'b0, wake = 1'b0, uv = 1'b0;
   logic ot = 1'b0, uvl = 1'b0, berr = 1'b0, serr = 1'b0;
   logic [1:0] rsel = 2'h0;
   logic [`BTC_ST_WIDTH-1:0] st;
   int num_errors = 0, n_compared = 0, i;
   btc_ctrl #(.FILT_CYC(4), .MODE_CYC(20), .REACT_CYC(2), .TIMEOUT_CYC(40)) DUT (
      .CLK_SYS(clk), .SRST(srst), .TX_DATA(txd), .TX_GATE_N(gate_n), .RX_DATA(rx),
      .GUARDIAN_ENABLE(guard), .STANDBY_REQ_N(stby_n), .FAULT_WAKE_N(fault), .BUS_NEG_DET(neg),
      .BUS_POS_DET(pos), .STAGE_OFF_DET(soff), .TX_ON(ron), .TX_POS(rpos), .BIAS_NORMAL(bias),
      .UV_SUPPLY(uv), .UV_LOGIC(uvl), .OVERTEMP(ot), .BUS_ERROR(berr), .SPI_ERROR(serr),
      .WAKE_DET(wake), .STATUS_READ(rd), .STATUS(st), .SERIAL_OUT_OE(oe), .NORMAL_MODE(nmode));
   btc_bus_model bus (.tx_on(ron), .tx_pos(rpos), .remote_sel(rsel), .neg_det(neg),
      .pos_det(pos), .stage_off(soff));
   // ====
   initial forever #2.5 clk = ~clk;
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic look(input int n);
      step(n);
      #1;
   endtask
   task automatic cmp(input logic [`BTC_ST_WIDTH-1:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_mode(input logic m);
      for (i = 0; i < 60 && nmode !== m; i++) look(1);
   endtask
   task automatic clear_read();
      step(1);
      rd <= 1'b1;
      step(1);
      rd <= 1'b0;
   endtask
   task automatic end_of_test();
      if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      step(3000);
      num_errors++;
      end_of_test();
   end
   // ====
   task automatic t_reset_glitch();
      step(20);
      srst <= 1'b0;
      look(1);
      cmp(st, `BTC_ST_RESET | (10'h001 << `BTC_ST_ACTIVITY_N));
      cmp({fault, rx, ron, nmode}, 4'hC);
      step(1);
      stby_n <= 1'b0;
      step(10);
      stby_n <= 1'b1;
      step(2);
      stby_n <= 1'b0;
      look(40);
      cmp(nmode, 1'b0);
   endtask
   task automatic t_normal_tx();
      step(1);
      gate_n <= 1'b0;
      stby_n <= 1'b1;
      wait_mode(1'b1);
      cmp(nmode, 1'b1);
      look(6);
      cmp(ron, 1'b0);
      step(1);
      gate_n <= 1'b1;
      clear_read();
      step(3);
      gate_n <= 1'b0;
      look(8);
      cmp({ron, rpos, rx}, 3'h4);
      step(1);
      txd <= 1'b1;
      look(8);
      cmp({ron, rpos, rx}, 3'h7);
      step(1);
      gate_n <= 1'b1;
      look(6);
      cmp(ron, 1'b0);
   endtask
   task automatic t_timeout();
      step(1);
      gate_n <= 1'b0;
      look(60);
      cmp({ron, fault, st[`BTC_ST_TIMEOUT]}, 3'h1);
      step(1);
      gate_n <= 1'b1;
      step(4);
      clear_read();
      look(3);
      cmp({fault, st[`BTC_ST_TIMEOUT]}, 2'h2);
   endtask
   task automatic t_guard();
      step(1);
      gate_n <= 1'b0;
      look(6);
      cmp(ron, 1'b1);
      step(1);
      guard <= 1'b0;
      look(10);
      cmp({ron, fault, st[`BTC_ST_GUARDIAN]}, 3'h1);
      step(1);
      guard <= 1'b1;
      gate_n <= 1'b1;
      step(4);
      clear_read();
      look(3);
      cmp(fault, 1'b1);
   endtask
   task automatic t_remote();
      for (int k = 1; k < 4; k++) begin
         step(1);
         rsel <= k[1:0] & 2'h3;
         look(6);
         cmp({rx, st[`BTC_ST_ACTIVITY_N]}, k == 1 ? 2'h0 : (k == 2 ? 2'h2 : 2'h3));
      end
   endtask
   task automatic t_detect();
      step(1);
      gate_n <= 1'b0;
      look(6);
      cmp(ron, 1'b1);
      step(1);
      ot <= 1'b1;
      look(8);
      cmp({ron, fault, st[`BTC_ST_OVERTEMP]}, 3'h1);
      step(1);
      ot <= 1'b0;
      gate_n <= 1'b1;
      berr <= 1'b1;
      serr <= 1'b1;
      look(8);
      cmp({fault, st[`BTC_ST_BUS_ERR], st[`BTC_ST_SPI_ERR]}, 3'h3);
      step(1);
      berr <= 1'b0;
      serr <= 1'b0;
      step(4);
      clear_read();
      look(3);
      cmp({fault, st[`BTC_ST_SPI_ERR:`BTC_ST_TIMEOUT]}, 6'h20);
   endtask
   task automatic t_standby_uv();
      step(1);
      rsel <= 2'h0;
      stby_n <= 1'b0;
      wait_mode(1'b0);
      cmp({nmode, fault, rx}, 3'h3);
      step(1);
      wake <= 1'b1;
      step(3);
      wake <= 1'b0;
      look(10);
      cmp({fault, rx, st[`BTC_ST_WAKE]}, 3'h1);
      clear_read();
      stby_n <= 1'b1;
      wait_mode(1'b1);
      step(1);
      uv <= 1'b1;
      wait_mode(1'b0);
      look(4);
      cmp({nmode, fault, rx, st[`BTC_ST_UV_SUPPLY]}, 4'h3);
      step(1);
      uv <= 1'b0;
      uvl <= 1'b1;
      look(6);
      cmp({fault, rx, oe, st[`BTC_ST_UV_LOGIC]}, 4'h1);
   endtask
   initial begin
      t_reset_glitch();
      t_normal_tx();
      t_timeout();
      t_guard();
      t_remote();
      t_detect();
      t_standby_uv();
      end_of_test();
   end
endmodule // test_bus_transceiver_ctrl_logic
bind btc_ctrl btc_ctrl_monitor #(.FILT_CYC(FILT_CYC), .MODE_CYC(MODE_CYC)) mon (
   .CLK_SYS(CLK_SYS), .SRST(SRST), .TX_GATE_N(TX_GATE_N), .RX_DATA(RX_DATA),
   .GUARDIAN_ENABLE(GUARDIAN_ENABLE), .STANDBY_REQ_N(STANDBY_REQ_N), .FAULT_WAKE_N(FAULT_WAKE_N),
   .BUS_NEG_DET(BUS_NEG_DET), .TX_ON(TX_ON), .UV_SUPPLY(UV_SUPPLY), .UV_LOGIC(UV_LOGIC),
   .STATUS_READ(STATUS_READ), .NORMAL_MODE(NORMAL_MODE), .STATUS(STATUS));
`default_nettype wire
